// File: bank6_pkg.sv
// Package with offsets, masks, reset values and bus states of the bank map
package bank6_pkg;
  localparam int          PC_W        = 15;      // Program counter width
  localparam int          MEM_DEPTH   = 256;     // Indirect data memory bytes
  localparam int          MEM_AW      = 8;       // Indirect memory address width
  localparam logic [4:0]  BANK_NUM    = 5'h06;   // Bank served by this slice
  localparam logic [6:0]  CORE_LAST   = 7'h0B;   // Last offset of the core window
  // Register indexes; byte address is four times the index
  localparam logic [11:0] IDX_IND0    = 12'h300; // indirect_port_zero
  localparam logic [11:0] IDX_IND1    = 12'h301; // indirect_port_one
  localparam logic [11:0] IDX_PC_LOW  = 12'h302; // pc_low_byte
  localparam logic [11:0] IDX_STATUS  = 12'h303; // core_status_flags
  localparam logic [11:0] IDX_P0L     = 12'h304; // pointer_zero_low
  localparam logic [11:0] IDX_P0H     = 12'h305; // pointer_zero_high
  localparam logic [11:0] IDX_P1L     = 12'h306; // pointer_one_low
  localparam logic [11:0] IDX_P1H     = 12'h307; // pointer_one_high
  localparam logic [11:0] IDX_BANK    = 12'h308; // bank_select
  localparam logic [11:0] IDX_WORK    = 12'h309; // working_register
  localparam logic [11:0] IDX_LATCH   = 12'h30A; // pc_high_latch
  localparam logic [11:0] IDX_INTCTL  = 12'h30B; // core_interrupt_control
  localparam logic [11:0] IDX_C3VL    = 12'h311; // channel3_value_low
  localparam logic [11:0] IDX_C3VH    = 12'h312; // channel3_value_high
  localparam logic [11:0] IDX_C3CON   = 12'h313; // channel3_control
  localparam logic [11:0] IDX_C3RST   = 12'h314; // channel3_pwm_restart
  localparam logic [11:0] IDX_C3AS    = 12'h315; // channel3_autoshutdown
  localparam logic [11:0] IDX_C3STR   = 12'h316; // channel3_steering
  localparam logic [11:0] IDX_C4VL    = 12'h318; // channel4_value_low
  localparam logic [11:0] IDX_C4VH    = 12'h319; // channel4_value_high
  localparam logic [11:0] IDX_C4CON   = 12'h31A; // channel4_control
  localparam logic [11:0] IDX_C5VL    = 12'h31C; // channel5_value_low
  localparam logic [11:0] IDX_C5VH    = 12'h31D; // channel5_value_high
  localparam logic [11:0] IDX_C5CON   = 12'h31E; // channel5_control
  // Implemented bit masks
  localparam logic [7:0]  MASK_NONE   = 8'h00;   // Nothing stored
  localparam logic [7:0]  MASK_BYTE   = 8'hFF;   // Full byte
  localparam logic [7:0]  MASK_FIVE   = 8'h1F;   // Low five bits
  localparam logic [7:0]  MASK_SEVEN  = 8'h7F;   // Low seven bits
  localparam logic [7:0]  MASK_SIX    = 8'h3F;   // Low six bits
  localparam logic [7:0]  MASK_ST_WR  = 8'h07;   // Writable status flags
  localparam int          ST_TO_BIT   = 4;       // Time-out flag position
  localparam int          ST_PD_BIT   = 3;       // Power-down flag position
  // Reset values
  localparam logic [7:0]  RST_ZERO    = 8'h00;   // Common cleared value
  localparam logic [7:0]  RST_STATUS  = 8'h18;   // Status at power-on
  localparam logic [7:0]  RST_STEER   = 8'h01;   // Steering at any reset

  // Bus slave data phase states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WR       = 3'b001,
    ST_RD_MEM   = 3'b010,
    ST_RD_LATCH = 3'b011,
    ST_RD_DONE  = 3'b100
  } bus_state_e;

  // Implemented bits of a bank offset
  function automatic logic [7:0] rd_mask(input logic [4:0] o);
    case (o)
      IDX_PC_LOW[4:0], IDX_P0L[4:0], IDX_P0H[4:0], IDX_P1L[4:0],
      IDX_P1H[4:0], IDX_WORK[4:0], IDX_INTCTL[4:0], IDX_C3VL[4:0],
      IDX_C3VH[4:0], IDX_C3CON[4:0], IDX_C3RST[4:0], IDX_C3AS[4:0],
      IDX_C4VL[4:0], IDX_C4VH[4:0], IDX_C5VL[4:0], IDX_C5VH[4:0]: rd_mask = MASK_BYTE;
      IDX_STATUS[4:0], IDX_BANK[4:0], IDX_C3STR[4:0]:            rd_mask = MASK_FIVE;
      IDX_LATCH[4:0]:                                            rd_mask = MASK_SEVEN;
      IDX_C4CON[4:0], IDX_C5CON[4:0]:                            rd_mask = MASK_SIX;
      default:                                                   rd_mask = MASK_NONE;
    endcase
  endfunction : rd_mask

  // Power-on value of a bank offset
  function automatic logic [7:0] por_val(input logic [4:0] o);
    case (o)
      IDX_STATUS[4:0]: por_val = RST_STATUS;
      IDX_C3STR[4:0]:  por_val = RST_STEER;
      default:         por_val = RST_ZERO;
    endcase
  endfunction : por_val

  // Bits kept unchanged by the other resets
  function automatic logic [7:0] soft_keep(input logic [4:0] o);
    case (o)
      IDX_P0L[4:0], IDX_P1L[4:0], IDX_WORK[4:0], IDX_C3VL[4:0], IDX_C3VH[4:0],
      IDX_C4VL[4:0], IDX_C4VH[4:0], IDX_C5VL[4:0], IDX_C5VH[4:0]: soft_keep = MASK_BYTE;
      IDX_STATUS[4:0]: soft_keep = MASK_ST_WR;
      default:         soft_keep = MASK_NONE;
    endcase
  endfunction : soft_keep
endpackage : bank6_pkg

// File: bank6_mem_if.sv
// Interface between the register bank and its indirect data memory
`timescale 1ns/1ps
`default_nettype none
interface bank6_mem_if;
  logic       we;    // Write strobe
  logic       re;    // Read strobe
  logic [7:0] addr;  // Byte address
  logic [7:0] wdata; // Write data
  logic [7:0] rdata; // Registered read data
  modport master (output we, re, addr, wdata, input rdata);
  modport slave  (input we, re, addr, wdata, output rdata);
endinterface : bank6_mem_if
`default_nettype wire

// File: bank6_data_mem.sv
// Small data memory reached through the indirect ports
`timescale 1ns/1ps
`default_nettype none
module bank6_data_mem
  import bank6_pkg::*;
(
  input  wire logic   sys_clk_i, // System clock
  input  wire logic   reset_i,   // Async reset, active high
  bank6_mem_if.slave  mem        // Memory access port
);
  typedef struct packed {
    logic [7:0] rdata; // Read data register
  } mem_state_s;

  logic [7:0] cells [MEM_DEPTH]; // Storage, not reset
  mem_state_s q;                 // Registered state
  mem_state_s next_q;            // Next state

  // Read data follows a read strobe by one edge
  always_comb begin
    next_q = q;
    if (mem.re) begin
      next_q.rdata = cells[mem.addr];
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Storage write
  always_ff @(posedge sys_clk_i) begin
    if (mem.we) begin
      cells[mem.addr] <= mem.wdata;
    end
  end

  assign mem.rdata = q.rdata;
endmodule : bank6_data_mem
`default_nettype wire

// File: bank6_register_map.sv
// Bank six register map behind an AHB-Lite slave
// Functional notes
// - Program counter upper byte has no address
// - Seven-bit high latch, top bit reads zero
// - Loading program counter copies latch into upper
// - Core offsets 0x00-0x0B decode in every bank
// - Unimplemented addresses and bits read zero
// - Listed reset values; some survive other resets
// - Bank select five bits; steering resets 01
`timescale 1ns/1ps
`default_nettype none
module bank6_register_map (
  input  wire logic                      sys_clk_i,        // System clock, 20 MHz
  input  wire logic                      reset_i,          // Power-on/brown-out reset
  input  wire logic                      soft_reset_i,     // Any other reset, sync
  input  wire logic                      timeout_flag_i,   // Time-out flag at soft reset
  input  wire logic                      powerdown_flag_i, // Power-down flag at soft reset
  input  wire logic                      hsel_i,           // Slave select
  input  wire logic [31:0]               haddr_i,          // Byte address
  input  wire logic [1:0]                htrans_i,         // Transfer type
  input  wire logic                      hwrite_i,         // Write when high
  input  wire logic [2:0]                hsize_i,          // Size, word only
  input  wire logic [31:0]               hwdata_i,         // Write data
  input  wire logic                      hready_i,         // Bus ready
  output logic      [31:0]               hrdata_o,         // Read data
  output logic                           hreadyout_o,      // Slave ready
  output logic                           hresp_o,          // Response, always OKAY
  output logic      [bank6_pkg::PC_W-1:0] pc_o,            // Program counter
  output logic      [4:0]                bank_select_o,    // Bank select value
  output logic      [7:0]                working_register_o // Working register
);
  import bank6_pkg::*;

  typedef struct packed {
    bus_state_e       state;   // Data phase state
    logic [11:0]      idx;     // Latched word index
    logic             wr;      // Latched direction
    logic [31:0]      rdata;   // Read data register
    logic [6:0]       pc_high; // Program counter upper part
    logic [31:0][7:0] regs;    // Bank offset storage
  } state_s;

  // Power-on contents of all offsets
  function automatic logic [31:0][7:0] por_all();
    logic [31:0][7:0] v;
    for (int k = 0; k < 32; k++) begin
      v[k] = por_val(5'(k));
    end
    return v;
  endfunction : por_all

  // Offset decodes to a register or an indirect port
  function automatic logic mapped(input logic [11:0] i);
    mapped = (i[6:0] <= CORE_LAST) ||
             (i[11:7] == BANK_NUM && i[6:5] == 2'b00 && rd_mask(i[4:0]) != MASK_NONE);
  endfunction : mapped

  // Offset is one of the indirect ports
  function automatic logic is_ind(input logic [11:0] i);
    is_ind = (i[6:1] == IDX_IND0[6:1]);
  endfunction : is_ind

  localparam state_s Q_RST = '{state: ST_IDLE, idx: 12'h000, wr: 1'b0,
                               rdata: 32'h0000_0000, pc_high: 7'h00,
                               regs: por_all()};

  state_s      q;       // Registered state
  state_s      next_q;  // Next state
  logic        accept;  // Address phase taken
  logic        accept_slot; // State may take a new address
  logic [7:0]  wbyte;   // Write data byte
  logic [4:0]  ofs;     // Latched register offset
  bank6_mem_if mem ();  // Indirect memory link

  // Indirect data memory
  bank6_data_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .mem       (mem)
  );

  // Next state: bus phases, register writes, soft reset
  always_comb begin
    next_q      = q;
    wbyte       = hwdata_i[7:0];
    ofs         = q.idx[4:0];
    accept      = hsel_i && htrans_i[1] && hready_i;
    accept_slot = (q.state == ST_IDLE) || (q.state == ST_WR) || (q.state == ST_RD_DONE);
    mem.we      = 1'b0;
    mem.re      = 1'b0;
    mem.wdata   = wbyte;
    // Pointer pair low byte selects the memory cell
    mem.addr    = q.idx[0] ? q.regs[IDX_P1L[4:0]] : q.regs[IDX_P0L[4:0]];
    case (q.state)
      ST_WR: begin
        // Write data phase, no wait
        if (!mapped(q.idx)) begin
          next_q.regs = q.regs;
        end else if (is_ind(q.idx)) begin
          mem.we = 1'b1;
        end else if (ofs == IDX_STATUS[4:0]) begin
          // Time-out and power-down stay read-only
          next_q.regs[ofs] = (q.regs[ofs] & ~MASK_ST_WR) | (wbyte & MASK_ST_WR);
        end else begin
          next_q.regs[ofs] = wbyte & rd_mask(ofs);
          if (ofs == IDX_PC_LOW[4:0]) begin
            next_q.pc_high = q.regs[IDX_LATCH[4:0]][6:0];
          end
        end
      end
      ST_RD_MEM: begin
        // Fetch the memory cell behind an indirect port
        mem.re       = mapped(q.idx) && is_ind(q.idx);
        next_q.state = ST_RD_LATCH;
      end
      ST_RD_LATCH: begin
        // Register the read answer
        if (!mapped(q.idx)) begin
          next_q.rdata = 32'h0000_0000;
        end else if (is_ind(q.idx)) begin
          next_q.rdata = {24'h00_0000, mem.rdata};
        end else begin
          next_q.rdata = {24'h00_0000, q.regs[ofs] & rd_mask(ofs)};
        end
        next_q.state = ST_RD_DONE;
      end
      ST_IDLE, ST_RD_DONE: begin
        // Nothing to finish
      end
      default: begin
        next_q.state = ST_IDLE;
      end
    endcase
    // New address phase
    if (accept_slot) begin
      if (accept) begin
        next_q.idx   = haddr_i[13:2];
        next_q.wr    = hwrite_i;
        next_q.state = hwrite_i ? ST_WR : ST_RD_MEM;
      end else begin
        next_q.state = ST_IDLE;
      end
    end
    // Other resets win over a register write in the same cycle; an indirect port write still reaches memory
    if (soft_reset_i) begin
      for (int k = 0; k < 32; k++) begin
        next_q.regs[k] = (q.regs[k] & soft_keep(5'(k))) | (por_val(5'(k)) & ~soft_keep(5'(k)));
      end
      next_q.regs[IDX_STATUS[4:0]][ST_TO_BIT] = timeout_flag_i;
      next_q.regs[IDX_STATUS[4:0]][ST_PD_BIT] = powerdown_flag_i;
      next_q.pc_high = 7'h00;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= Q_RST;
    end else begin
      q <= next_q;
    end
  end

  // Outputs
  assign hrdata_o           = q.rdata;
  assign hreadyout_o        = (q.state != ST_RD_MEM) && (q.state != ST_RD_LATCH);
  assign hresp_o            = 1'b0;
  // Upper byte only reachable through the program counter output
  assign pc_o               = {q.pc_high, q.regs[IDX_PC_LOW[4:0]]};
  assign bank_select_o      = q.regs[IDX_BANK[4:0]][4:0];
  assign working_register_o = q.regs[IDX_WORK[4:0]];

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  logic pc_low_write; // Write to the low byte commits now
  assign pc_low_write = (q.state == ST_WR) && (q.idx[6:0] == IDX_PC_LOW[6:0]);

  a_pc_high_hold: assert property (!pc_low_write && !soft_reset_i |=> $stable(q.pc_high))
    else $error("pc upper part changed without a load");
  a_latch_top: assert property (q.regs[IDX_LATCH[4:0]][7] == 1'b0)
    else $error("pc high latch top bit set");
  a_pc_load: assert property (pc_low_write && !soft_reset_i |=> pc_o[14:8] == $past(q.regs[IDX_LATCH[4:0]][6:0]))
    else $error("pc upper part not loaded from latch");
  a_core_mirror: assert property (q.state == ST_RD_LATCH && q.idx[6:0] <= CORE_LAST && !is_ind(q.idx)
      && !soft_reset_i |=> hrdata_o == {24'h00_0000, q.regs[q.idx[4:0]] & rd_mask(q.idx[4:0])})
    else $error("core register read mismatch");
  a_unmapped_zero: assert property (q.state == ST_RD_LATCH && !mapped(q.idx) |=> hrdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_soft_keep: assert property (soft_reset_i |=> $stable(working_register_o) ##0 bank_select_o == 5'h00)
    else $error("soft reset handled wrong");
  a_steer_reset: assert property (soft_reset_i |=> q.regs[IDX_C3STR[4:0]] == RST_STEER)
    else $error("steering reset value wrong");
  a_bank_width: assert property (q.regs[IDX_BANK[4:0]][7:5] == 3'b000)
    else $error("bank select upper bits set");
  a_ind_write: assert property (q.state == ST_WR && is_ind(q.idx) |-> mem.we)
    else $error("indirect write not sent to memory");
  a_read_wait: assert property (accept && accept_slot && !hwrite_i |=> !hreadyout_o [*2] ##1 hreadyout_o)
    else $error("read wait states wrong");

  c_pc_low_load: cover property (pc_low_write);
  c_ind_read: cover property (q.state == ST_RD_MEM && is_ind(q.idx));
  c_soft_rst: cover property (soft_reset_i ##1 accept);
  c_unmapped: cover property (q.state == ST_RD_DONE && !mapped(q.idx));
endmodule : bank6_register_map
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the bank six register map over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk;      // 20 MHz clock
  logic        reset;        // Power-on reset
  logic        soft_reset;   // Other reset
  logic        timeout_flag; // Status flag source
  logic        pdown_flag;   // Status flag source
  logic        hsel;         // Slave select
  logic [31:0] haddr;        // Byte address
  logic [1:0]  htrans;       // Transfer type
  logic        hwrite;       // Write flag
  logic [31:0] hwdata;       // Write data
  logic [31:0] hrdata;       // Read data
  logic        hreadyout;    // Slave ready, also bus ready
  logic        hresp;        // Response
  logic [14:0] pc;           // Program counter
  logic [4:0]  bank_sel;     // Bank select value
  logic [7:0]  work_reg;     // Working register
  logic [7:0]  rd;           // Last read byte
  int          error_cnt;    // Mismatches
  int          comparisons;  // Checks made
  // Implemented bits per offset, equal to read-back after writing all ones
  logic [7:0] mask [32] = '{8'h00, 8'h00, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'h7F, 8'hFF,
                            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h00,
                            8'hFF, 8'hFF, 8'h3F, 8'h00, 8'hFF, 8'hFF, 8'h3F, 8'h00};
  // Offsets that survive the other resets
  logic [31:0] keep = 32'h3306_0250;

  bank6_register_map dut (
    .sys_clk_i(sys_clk), .reset_i(reset), .soft_reset_i(soft_reset), .timeout_flag_i(timeout_flag),
    .powerdown_flag_i(pdown_flag), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .pc_o(pc), .bank_select_o(bank_sel), .working_register_o(work_reg));

  // Clock generation
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Compare one value
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Wait for hready sampled high at a rising edge
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) chk("hready", {31'h0, hreadyout}, 32'h1);
  endtask : wait_ready

  // One single word transfer; read byte lands in rd
  task xfer(input logic wr, input logic [11:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {18'h0, idx, 2'b00};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_ready();
    rd = hrdata[7:0];
    if (!wr) chk("upper read bits", {8'h0, hrdata[31:8]}, 32'h0);
    chk("response", {31'h0, hresp}, 32'h0);
    // A write commits at this edge; let outputs settle before callers look
    #1;
  endtask : xfer

  // Read one register and compare
  task rd_chk(input logic [11:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk($sformatf("index %h", idx), {24'h0, rd}, {24'h0, exp});
  endtask : rd_chk

  // Power-on values of bank offsets 0x02-0x1F
  task por_check;
    for (int o = 2; o < 32; o++) begin
      rd_chk(12'h300 | 12'(o), (o == 3) ? 8'h18 : (o == 22) ? 8'h01 : 8'h00);
    end
    chk("pc", {17'h0, pc}, 32'h0);
    chk("bank out", {27'h0, bank_sel}, 32'h0);
    chk("work out", {24'h0, work_reg}, 32'h0);
  endtask : por_check

  // Power-on reset for two cycles
  task por_pulse;
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
  endtask : por_pulse

  // Counts and verdict
  task results;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Watchdog against a hung bus
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    results();
  end

  // Main sequence
  initial begin
    error_cnt = 0;
    comparisons = 0;
    reset = 1'b1;
    soft_reset = 1'b0;
    timeout_flag = 1'b0;
    pdown_flag = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    por_check();
    // Fill offsets 0x02-0x1F with ones, read back implemented bits only
    for (int o = 2; o < 32; o++) xfer(1'b1, 12'h300 | 12'(o), 8'hFF);
    for (int o = 2; o < 32; o++) rd_chk(12'h300 | 12'(o), mask[o]);
    chk("bank out", {27'h0, bank_sel}, 32'h1F);
    chk("work out", {24'h0, work_reg}, 32'hFF);
    // Other reset: kept registers, flag bits loaded from inputs
    @(posedge sys_clk);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    for (int o = 2; o < 32; o++) begin
      rd_chk(12'h300 | 12'(o), keep[o] ? mask[o] : (o == 3) ? 8'h0F : (o == 22) ? 8'h01 : 8'h00);
    end
    chk("pc soft", {17'h0, pc}, 32'h0);
    // Core window in other banks reaches the same register
    xfer(1'b1, 12'h009, 8'h5A);
    rd_chk(12'h309, 8'h5A);
    rd_chk(12'hF89, 8'h5A);
    chk("work mirror", {24'h0, work_reg}, 32'h5A);
    xfer(1'b1, 12'h388, 8'h03);
    chk("bank mirror", {27'h0, bank_sel}, 32'h03);
    // Non-core offsets outside this bank do not decode
    xfer(1'b1, 12'h391, 8'h55);
    rd_chk(12'h391, 8'h00);
    rd_chk(12'h311, 8'hFF);
    // Latch holds until the low byte is loaded
    xfer(1'b1, 12'h30A, 8'h55);
    chk("pc hold", {17'h0, pc}, 32'h0);
    xfer(1'b1, 12'h302, 8'h34);
    chk("pc load", {17'h0, pc}, {17'h0, 7'h55, 8'h34});
    xfer(1'b1, 12'h30A, 8'hD5);
    rd_chk(12'h30A, 8'h55);
    chk("pc stay", {17'h0, pc}, {17'h0, 7'h55, 8'h34});
    // Indirect ports reach memory through either pointer
    xfer(1'b1, 12'h304, 8'h40);
    xfer(1'b1, 12'h306, 8'h41);
    xfer(1'b1, 12'h300, 8'hA5);
    xfer(1'b1, 12'h301, 8'h3C);
    xfer(1'b1, 12'h304, 8'h41);
    xfer(1'b1, 12'h306, 8'h40);
    rd_chk(12'h300, 8'h3C);
    rd_chk(12'h301, 8'hA5);
    rd_chk(12'h304, 8'h41);
    // Second power-on reset in mid-run
    por_pulse();
    por_check();
    results();
  end
endmodule : tb
`default_nettype wire
